// File: hw/psu_ctrl.sv
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "psu_ctrl_map.svh"
// ----------------------------------------------------------------
// Notes on behaviour
// [R1] Transient source is either bus software trigger or immediate.
// [R2] Initiate moves the transient machine from idle to initiated.
// [R3] Immediate source: initiate copies pending setpoints into active at once.
// [R4] Bus source: initiate waits for a software trigger, holding pendings.
// [R5] After the setpoint change the machine returns to idle.
// [R6] Abort while waiting cancels without touching outputs, back to idle.
// [R7] Reset starts idle; triggers received while idle are ignored.
// [R8] Abort, reset command, device clear or break force idle from any state.
// [R9] Abort keeps the stored pending voltage value.
// [R10] After trigger active reads former pending; reset command zeroes both.
// [R11] Writing active voltage before trigger makes pending equal the new value.
// [R12] Absolute tracking adds the same delta to every tracked channel.
// [R13] Percentage tracking scales every tracked channel by the same percent.
// [R14] Plain setpoint writes rejected with error while tracking is enabled.
// [R15] Percent is taken against the stored baseline, readable by software.
// [R16] Anchor command copies present outputs into the baseline.
// [R17] Untracked reference moves alone; tracked channels stay unchanged.
// [R18] Status groups hold condition, event, enable and transition filters.
// [R19] Condition and event read-only; enable read-write. The transition filters can be written but not read back.
// [R20] Operation bit 8 and each channel summary bit 8 show constant voltage; the per-channel CV summary is in bits 19:16 of the instrument register.
// [R21] Questionable bit 0 flags overvoltage without naming the channel.
// [R22] Instrument subregister one bit per bad channel; summaries carry own OV.
// [R23] Power-up flag bit 7 set at power-up; power-up clear keeps enables. Reset clears ese whatever psc holds.
// [R24] Transient source defaults to immediate, also after reset command.
// [R25] Percent current value 0 to 200, default 0, restored on reset command.
// [R26] A trigger applies pending voltage and current in the same update.
module psu_ctrl
   import psu_ctrl_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        nrst_i,
   // Register port
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   // Host interface events
   input  wire logic        dev_clear_i,
   input  wire logic        ser_break_i,
   // Analog status per channel
   input  wire logic [3:0]  cv_i,
   input  wire logic [3:0]  ov_i,
   // Setpoints to the regulators and error flag
   output psu_ctrl_pkg::setpt_t vset_o,
   output psu_ctrl_pkg::setpt_t iset_o,
   output logic      [63:0] ch_vset_o,
   output logic             err_o
);
   import psu_ctrl_pkg::*;

   localparam int NCH = 4;

   typedef struct packed {
      trans_state_t         tst;
      trig_src_t            src;
      setpt_t               v_act;
      setpt_t               i_act;
      setpt_t               v_pend;
      setpt_t               i_pend;
      logic                 trk_en;
      logic                 trk_pct;
      logic [3:0]           trk_mask;
      logic [1:0]           ref_ch;
      logic [1:0]           ch_sel;
      logic [NCH-1:0][15:0] ch_v;
      logic [NCH-1:0][15:0] base_v;
      logic [15:0]          pct_v;
      logic [15:0]          pct_i;
      logic [15:0]          oper_en;
      logic [15:0]          oper_ptr;
      logic [15:0]          oper_ntr;
      logic [15:0]          ques_en;
      logic [15:0]          ques_ptr;
      logic [15:0]          ques_ntr;
      logic [7:0]           esr;
      logic [7:0]           ese;
      logic                 psc;
      logic [7:0]           err_cnt;
      logic                 err;
      logic [31:0]          rdata;
   } st_t;

   st_t st_ff;
   st_t nxt_st;

   // ----------------------------------------------------------------
   // Status groups
   // ----------------------------------------------------------------
   logic [15:0] oper_cond;
   logic [15:0] ques_cond;
   logic [15:0] oper_evt;
   logic [15:0] ques_evt;
   logic        oper_clr;
   logic        ques_clr;

   always_comb begin
      oper_cond = 16'h0000;
      oper_cond[`OPER_CV_BIT] = |cv_i;                      // R20
      ques_cond = 16'h0000;
      ques_cond[`QUES_OV_BIT] = |ov_i;                      // R21
   end

   assign oper_clr = rd_i && (addr_i == `REG_OPER_EVT);
   assign ques_clr = rd_i && (addr_i == `REG_QUES_EVT);

   status_group u_oper (
      .sys_clk_i (sys_clk_i),
      .nrst_i    (nrst_i),
      .cond_i    (oper_cond),
      .ptr_i     (st_ff.oper_ptr),
      .ntr_i     (st_ff.oper_ntr),
      .en_i      (st_ff.oper_en),
      .evt_clr_i (oper_clr),
      .evt_o     (oper_evt),
      .summ_o    ()
   );

   status_group u_ques (
      .sys_clk_i (sys_clk_i),
      .nrst_i    (nrst_i),
      .cond_i    (ques_cond),
      .ptr_i     (st_ff.ques_ptr),
      .ntr_i     (st_ff.ques_ntr),
      .en_i      (st_ff.ques_en),
      .evt_clr_i (ques_clr),
      .evt_o     (ques_evt),
      .summ_o    ()
   );

   // ----------------------------------------------------------------
   // Tracking arithmetic, one lane per channel
   // ----------------------------------------------------------------
   logic [NCH-1:0][15:0] abs_res;
   logic [NCH-1:0][15:0] pct_res;

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_trk
         logic [31:0] prod;
         assign prod = 32'(st_ff.base_v[g]) * 32'(wdata_i[15:0]);
         // Percent of baseline, never of the present output
         assign pct_res[g] = 16'(prod / 32'd100);                    // R13 R15
         assign abs_res[g] = st_ff.ch_v[g] + wdata_i[15:0];          // R12
      end
   endgenerate

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic        wr_ok;
   logic        cmd_rst;
   logic        go_idle;
   logic        fire;
   logic [3:0]  lanes;

   always_comb begin
      nxt_st  = st_ff;
      nxt_st.err = 1'b0;
      nxt_st.rdata = 32'h0000_0000;
      cmd_rst = wr_i && (addr_i == `REG_TRIG_CTRL) && wdata_i[`TRIG_CTRL_RST];
      go_idle = cmd_rst || dev_clear_i || ser_break_i
              || (wr_i && (addr_i == `REG_TRIG_CTRL) && wdata_i[`TRIG_CTRL_ABORT]); // R8
      fire = 1'b0;
      wr_ok = 1'b1;
      // Reference alone when untracked, otherwise all tracked channels
      lanes = st_ff.trk_mask[st_ff.ref_ch] ? st_ff.trk_mask
                                           : (4'h1 << st_ff.ref_ch);  // R17

      // Transient trigger machine
      case (st_ff.tst)
         TR_IDLE: begin
            // Triggers are ignored here
            if (wr_i && (addr_i == `REG_TRIG_CTRL) && wdata_i[`TRIG_CTRL_INIT]
                && !go_idle) begin                                   // R7
               nxt_st.tst = TR_INIT;                                 // R2
            end
         end
         TR_INIT: begin
            if (st_ff.src == SRC_IMM) begin
               fire = 1'b1;                                          // R1 R3
            end else begin
               nxt_st.tst = TR_WAIT;                                 // R4
            end
         end
         TR_WAIT: begin
            if (wr_i && (addr_i == `REG_TRIG_CTRL) && wdata_i[`TRIG_CTRL_FIRE]) begin
               fire = 1'b1;                                          // R1
            end
         end
         default: nxt_st.tst = TR_IDLE;
      endcase
      // An abort in the same write as the trigger wins, so outputs stay put
      fire = fire && !go_idle;                                       // R6

      if (fire) begin
         nxt_st.v_act = st_ff.v_pend;                                // R10 R26
         nxt_st.i_act = st_ff.i_pend;                                // R26
         nxt_st.tst   = TR_IDLE;                                     // R5
      end

      // Register writes
      if (wr_i) begin
         if (addr_i == `REG_TRIG_CTRL) begin
            nxt_st.src = wdata_i[`TRIG_CTRL_SRC] ? SRC_BUS : SRC_IMM;
         end else if (addr_i == `REG_VSET_ACT) begin
            if (st_ff.trk_en) begin
               wr_ok = 1'b0;                                         // R14
            end else begin
               nxt_st.v_act  = wdata_i[15:0];
               nxt_st.v_pend = wdata_i[15:0];                        // R11
            end
         end else if (addr_i == `REG_ISET_ACT) begin
            if (st_ff.trk_en) begin
               wr_ok = 1'b0;                                         // R14
            end else begin
               nxt_st.i_act  = wdata_i[15:0];
               nxt_st.i_pend = wdata_i[15:0];
            end
         end else if (addr_i == `REG_VSET_PEND) begin
            nxt_st.v_pend = wdata_i[15:0];
         end else if (addr_i == `REG_ISET_PEND) begin
            nxt_st.i_pend = wdata_i[15:0];
         end else if (addr_i == `REG_TRK_CTRL) begin
            if (wdata_i[`TRK_CTRL_EN] && !st_ff.trk_en) begin
               nxt_st.base_v = st_ff.ch_v;                           // R15
            end
            nxt_st.trk_en   = wdata_i[`TRK_CTRL_EN];
            nxt_st.trk_pct  = wdata_i[`TRK_CTRL_PCT];
            nxt_st.trk_mask = wdata_i[11:8];
            nxt_st.ref_ch   = wdata_i[17:16];
         end else if (addr_i == `REG_TRK_ABS_V) begin
            if (!st_ff.trk_en || st_ff.trk_pct) begin
               wr_ok = 1'b0;
            end else begin
               for (int c = 0; c < NCH; c++) begin
                  if (lanes[c]) nxt_st.ch_v[c] = abs_res[c];         // R12 R17
               end
            end
         end else if (addr_i == `REG_TRK_PCT_V) begin
            if (!st_ff.trk_en || !st_ff.trk_pct || wdata_i[15:0] > `PCT_MAX) begin
               wr_ok = 1'b0;
            end else begin
               nxt_st.pct_v = wdata_i[15:0];
               for (int c = 0; c < NCH; c++) begin
                  if (lanes[c]) nxt_st.ch_v[c] = pct_res[c];         // R13 R17
               end
            end
         end else if (addr_i == `REG_TRK_PCT_I) begin
            if (wdata_i[15:0] > `PCT_MAX) begin
               wr_ok = 1'b0;                                         // R25
            end else begin
               nxt_st.pct_i = wdata_i[15:0];
            end
         end else if (addr_i == `REG_TRK_CMD) begin
            if (wdata_i[`TRK_CMD_ANCHOR]) begin
               nxt_st.base_v = st_ff.ch_v;                           // R16
            end
         end else if (addr_i == `REG_CH_SEL) begin
            nxt_st.ch_sel = wdata_i[1:0];
         end else if (addr_i == `REG_CH_V) begin
            if (st_ff.trk_en) begin
               wr_ok = 1'b0;                                         // R14
            end else begin
               nxt_st.ch_v[st_ff.ch_sel] = wdata_i[15:0];
            end
         end else if (addr_i == `REG_OPER_EN) begin
            nxt_st.oper_en = wdata_i[15:0];                          // R19
         end else if (addr_i == `REG_OPER_PTR) begin
            nxt_st.oper_ptr = wdata_i[15:0];
         end else if (addr_i == `REG_OPER_NTR) begin
            nxt_st.oper_ntr = wdata_i[15:0];
         end else if (addr_i == `REG_QUES_EN) begin
            nxt_st.ques_en = wdata_i[15:0];
         end else if (addr_i == `REG_QUES_PTR) begin
            nxt_st.ques_ptr = wdata_i[15:0];
         end else if (addr_i == `REG_QUES_NTR) begin
            nxt_st.ques_ntr = wdata_i[15:0];
         end else if (addr_i == `REG_ESE) begin
            nxt_st.ese = wdata_i[7:0];                               // R23
         end else if (addr_i == `REG_PSC) begin
            nxt_st.psc = wdata_i[0];
         end
      end

      // Abort, clear and command reset override; pending values kept on abort
      if (go_idle) begin
         nxt_st.tst = TR_IDLE;                                       // R6 R8 R9
      end
      if (cmd_rst) begin
         nxt_st.src    = SRC_IMM;                                    // R24
         nxt_st.v_act  = 16'h0000;                                   // R10
         nxt_st.v_pend = 16'h0000;
         nxt_st.i_act  = 16'h0000;
         nxt_st.i_pend = 16'h0000;
         nxt_st.pct_v  = `PCT_V_RST;
         nxt_st.pct_i  = `PCT_I_RST;                                 // R25
         nxt_st.trk_pct  = 1'b0;
         nxt_st.trk_mask = `TRK_MASK_RST;
      end

      if (!wr_ok) begin
         nxt_st.err = 1'b1;                                          // R14
         nxt_st.err_cnt = st_ff.err_cnt + 8'h01;
      end

      // Reads: setpoint, tracking and status registers; event registers and ESR clear on read
      if (rd_i) begin
         if (addr_i == `REG_TRIG_CTRL) begin
            nxt_st.rdata = {29'h0, st_ff.tst};
         end else if (addr_i == `REG_VSET_ACT) begin
            nxt_st.rdata = {16'h0000, st_ff.v_act};
         end else if (addr_i == `REG_ISET_ACT) begin
            nxt_st.rdata = {16'h0000, st_ff.i_act};
         end else if (addr_i == `REG_VSET_PEND) begin
            nxt_st.rdata = {16'h0000, st_ff.v_pend};
         end else if (addr_i == `REG_ISET_PEND) begin
            nxt_st.rdata = {16'h0000, st_ff.i_pend};
         end else if (addr_i == `REG_TRK_CTRL) begin
            nxt_st.rdata = {14'h0, st_ff.ref_ch, 4'h0, st_ff.trk_mask,
                            6'h00, st_ff.trk_pct, st_ff.trk_en};
         end else if (addr_i == `REG_TRK_PCT_V) begin
            nxt_st.rdata = {16'h0000, st_ff.pct_v};
         end else if (addr_i == `REG_TRK_PCT_I) begin
            nxt_st.rdata = {16'h0000, st_ff.pct_i};
         end else if (addr_i == `REG_BASE_V) begin
            nxt_st.rdata = {16'h0000, st_ff.base_v[st_ff.ref_ch]};   // R15
         end else if (addr_i == `REG_CH_V) begin
            nxt_st.rdata = {16'h0000, st_ff.ch_v[st_ff.ch_sel]};
         end else if (addr_i == `REG_OPER_COND) begin
            nxt_st.rdata = {16'h0000, oper_cond};
         end else if (addr_i == `REG_OPER_EVT) begin
            nxt_st.rdata = {16'h0000, oper_evt};
         end else if (addr_i == `REG_OPER_EN) begin
            nxt_st.rdata = {16'h0000, st_ff.oper_en};
         end else if (addr_i == `REG_QUES_COND) begin
            nxt_st.rdata = {16'h0000, ques_cond};
         end else if (addr_i == `REG_QUES_EVT) begin
            nxt_st.rdata = {16'h0000, ques_evt};
         end else if (addr_i == `REG_QUES_EN) begin
            nxt_st.rdata = {16'h0000, st_ff.ques_en};
         end else if (addr_i == `REG_QINST_COND) begin
            // Bits 3:0 abnormal channels; per-channel summary in [19:16] CV, [23:20] OV
            nxt_st.rdata = {8'h00, ov_i, cv_i, 12'h000, ov_i};       // R20 R22
         end else if (addr_i == `REG_ESR) begin
            nxt_st.rdata = {24'h0, st_ff.esr};
            nxt_st.esr   = 8'h00;
         end else if (addr_i == `REG_ESE) begin
            nxt_st.rdata = {24'h0, st_ff.ese};
         end else if (addr_i == `REG_PSC) begin
            nxt_st.rdata = {31'h0, st_ff.psc};
         end else if (addr_i == `REG_ERR_CNT) begin
            nxt_st.rdata = {24'h0, st_ff.err_cnt};
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_ff          <= '0;
         st_ff.tst      <= TR_IDLE;                                  // R7
         st_ff.src      <= SRC_IMM;                                  // R24
         st_ff.trk_mask <= `TRK_MASK_RST;
         st_ff.pct_v    <= `PCT_V_RST;
         st_ff.pct_i    <= `PCT_I_RST;
         st_ff.esr      <= 8'h80;                                    // R23
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign vset_o    = st_ff.v_act;
   assign iset_o    = st_ff.i_act;
   assign ch_vset_o = st_ff.ch_v;
   assign err_o     = st_ff.err;
   assign rdata_o   = st_ff.rdata;

   AST_IMM_FIRE: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      (st_ff.tst == TR_INIT && st_ff.src == SRC_IMM && !go_idle)
      |=> (vset_o == $past(st_ff.v_pend) && st_ff.tst == TR_IDLE))        // R3
      else $error("immediate source did not apply pending");
   AST_BUS_WAIT: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      (st_ff.tst == TR_INIT && st_ff.src == SRC_BUS && !go_idle)
      |=> st_ff.tst == TR_WAIT)                                           // R4
      else $error("bus source did not wait");
   AST_ABORT: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      go_idle |=> (st_ff.tst == TR_IDLE && ($stable(st_ff.v_pend) || $past(cmd_rst)
                   || $past(wr_i && addr_i != `REG_TRIG_CTRL))))         // R8 R9
      else $error("abort did not idle");
   AST_IDLE_IGN: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      (st_ff.tst == TR_IDLE && !(wr_i && addr_i == `REG_VSET_ACT) && !cmd_rst)
      |=> $stable(vset_o))                                                // R7
      else $error("idle trigger changed output");
   AST_TRK_REJ: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      (st_ff.trk_en && wr_i && addr_i == `REG_VSET_ACT) |=> err_o && $stable(vset_o)) // R14
      else $error("plain write accepted while tracking");
   AST_TRIG_PAIR: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      fire |=> (iset_o == $past(st_ff.i_pend)))                           // R26
      else $error("current not applied with voltage");
   AST_ANCHOR: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      (wr_i && addr_i == `REG_TRK_CMD && wdata_i[0]) |=> st_ff.base_v == $past(st_ff.ch_v)) // R16
      else $error("anchor did not capture outputs");
   AST_RST_SRC: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      cmd_rst |=> (st_ff.src == SRC_IMM && vset_o == 16'h0000 && st_ff.pct_i == 16'h0000)) // R24
      else $error("command reset defaults wrong");
endmodule // psu_ctrl

// File: hw/psu_ctrl_map.svh
`ifndef PSU_CTRL_MAP_SVH
`define PSU_CTRL_MAP_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define REG_TRIG_CTRL    8'h00
`define REG_VSET_ACT     8'h04
`define REG_ISET_ACT     8'h08
`define REG_VSET_PEND    8'h0C
`define REG_ISET_PEND    8'h10
`define REG_TRK_CTRL     8'h14
`define REG_TRK_ABS_V    8'h18
`define REG_TRK_ABS_I    8'h1C
`define REG_TRK_PCT_V    8'h20
`define REG_TRK_PCT_I    8'h24
`define REG_TRK_CMD      8'h28
`define REG_BASE_V       8'h2C
`define REG_BASE_I       8'h30
`define REG_CH_SEL       8'h34
`define REG_CH_V         8'h38
`define REG_OPER_COND    8'h40
`define REG_OPER_EVT     8'h44
`define REG_OPER_EN      8'h48
`define REG_OPER_PTR     8'h4C
`define REG_OPER_NTR     8'h50
`define REG_QUES_COND    8'h54
`define REG_QUES_EVT     8'h58
`define REG_QUES_EN      8'h5C
`define REG_QUES_PTR     8'h60
`define REG_QUES_NTR     8'h64
`define REG_QINST_COND   8'h68
`define REG_ESR          8'h6C
`define REG_ESE          8'h70
`define REG_PSC          8'h74
`define REG_STATUS       8'h78
`define REG_ERR_CNT      8'h7C
// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define TRIG_CTRL_SRC    0
`define TRIG_CTRL_INIT   1
`define TRIG_CTRL_FIRE   2
`define TRIG_CTRL_ABORT  3
`define TRIG_CTRL_RST    4
`define TRK_CTRL_EN      0
`define TRK_CTRL_PCT     1
`define TRK_CMD_ANCHOR   0
`define OPER_CV_BIT      8
`define QUES_OV_BIT      0
`define ESR_PON_BIT      7
// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define PCT_MAX          16'h00C8
`define PCT_V_RST        16'h0064
`define PCT_I_RST        16'h0000
`define TRK_MASK_RST     4'h3
`endif

// File: hw/psu_ctrl_pkg.sv
package psu_ctrl_pkg;
   typedef logic [15:0] setpt_t;
   typedef enum logic [2:0] {
      TR_IDLE = 3'b001,
      TR_INIT = 3'b010,
      TR_WAIT = 3'b100
   } trans_state_t;
   typedef enum logic [1:0] {
      SRC_IMM = 2'b00,
      SRC_BUS = 2'b01
   } trig_src_t;
endpackage

// File: hw/status_group.sv
`timescale 1ns/10ps
`include "psu_ctrl_map.svh"
// Condition / transition filters / sticky event / enable summary group
module status_group (
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        nrst_i,
   // Condition, filters, enable and event clear
   input  wire logic [15:0] cond_i,
   input  wire logic [15:0] ptr_i,
   input  wire logic [15:0] ntr_i,
   input  wire logic [15:0] en_i,
   input  wire logic        evt_clr_i,
   // Results
   output logic      [15:0] evt_o,
   output logic             summ_o
);
   typedef struct packed {
      logic [15:0] prev;
      logic [15:0] evt;
      logic        summ;
   } sg_st_t;
   sg_st_t st_ff;
   sg_st_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.prev = cond_i;
      // Set beats clear so a transition in the clearing read is kept
      nxt_st.evt = (evt_clr_i ? 16'h0000 : st_ff.evt)
                 | (cond_i & ~st_ff.prev & ptr_i)
                 | (~cond_i & st_ff.prev & ntr_i);          // R18
      nxt_st.summ = |(nxt_st.evt & en_i);                   // R19
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign evt_o  = st_ff.evt;
   assign summ_o = st_ff.summ;

   AST_EVT_RISE: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      (cond_i[0] && !st_ff.prev[0] && ptr_i[0]) |=> evt_o[0])   // R18
      else $error("rising condition not latched");
endmodule // status_group

// File: tb/host_link.sv
`timescale 1ns/10ps
// -------------------------------------------
// Host line events and analog status levels
// -------------------------------------------
module host_link (
   // Clock
   input  wire logic       sys_clk_i,
   // Requests from the bench
   input  wire logic       clr_req_i,
   input  wire logic       brk_req_i,
   input  wire logic [3:0] cv_req_i,
   input  wire logic [3:0] ov_req_i,
   // Toward the block
   output logic            dev_clear_o = 1'b0,
   output logic            ser_break_o = 1'b0,
   output logic      [3:0] cv_o        = 4'h0,
   output logic      [3:0] ov_o        = 4'h0
);
   // Launched on the edge, as a real host line would be
   always @(posedge sys_clk_i) begin
      dev_clear_o <= clr_req_i;
      ser_break_o <= brk_req_i;
      cv_o        <= cv_req_i;
      ov_o        <= ov_req_i;
   end
endmodule // host_link

// File: tb/psu_ctrl_tb.sv
`timescale 1ns/10ps
`include "psu_ctrl_map.svh"
module psu_ctrl_tb;
   import psu_ctrl_pkg::*;
   logic sys_clk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, clr = 1'b0, brk = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0, rdata_o;
   logic [3:0] cv_req = 4'h0, ov_req = 4'h0, cv_i, ov_i;
   logic dev_clear_i, ser_break_i, err_o;
   setpt_t vset_o, iset_o;
   logic [63:0] ch_vset_o;
   int n_mismatch = 0, n_compared = 0;
   always #5 sys_clk_i = ~sys_clk_i;
   psu_ctrl u_psu_ctrl (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .dev_clear_i(dev_clear_i),
      .ser_break_i(ser_break_i), .cv_i(cv_i), .ov_i(ov_i), .vset_o(vset_o), .iset_o(iset_o),
      .ch_vset_o(ch_vset_o), .err_o(err_o));
   host_link u_host_link (.sys_clk_i(sys_clk_i), .clr_req_i(clr), .brk_req_i(brk),
      .cv_req_i(cv_req), .ov_req_i(ov_req), .dev_clear_o(dev_clear_i),
      .ser_break_o(ser_break_i), .cv_o(cv_i), .ov_o(ov_i));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge sys_clk_i);
      wr_i    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge sys_clk_i);
      rd_i   <= 1'b0;
      #1 chk(rdata_o, e);
   endtask
   task automatic summarize();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      rd(`REG_ESR, 32'h80);
      rd(`REG_ESR, 32'h0);
      rd(8'h80, 32'h0);
      wr(`REG_VSET_PEND, 32'h10);
      wr(`REG_ISET_PEND, 32'h20);
      wr(`REG_TRIG_CTRL, 32'h2);
      tk(2);
      chk({vset_o, iset_o}, 32'h0010_0020);
      wr(`REG_VSET_PEND, 32'h30);
      wr(`REG_TRIG_CTRL, 32'h3);
      tk(3);
      chk({vset_o, iset_o}, 32'h0010_0020);
      wr(`REG_TRIG_CTRL, 32'h5);
      tk(1);
      chk({vset_o, iset_o}, 32'h0030_0020);
      wr(`REG_VSET_PEND, 32'h40);
      wr(`REG_TRIG_CTRL, 32'h3);
      wr(`REG_TRIG_CTRL, 32'h9);
      wr(`REG_TRIG_CTRL, 32'h5);
      tk(1);
      chk({16'h0, vset_o}, 32'h30);
      rd(`REG_VSET_PEND, 32'h40);
      for (int k = 0; k < 2; k++) begin
         wr(`REG_TRIG_CTRL, 32'h3);
         clr <= (k == 0);
         brk <= (k == 1);
         tk(1);
         clr <= 1'b0;
         brk <= 1'b0;
         wr(`REG_TRIG_CTRL, 32'h5);
         tk(1);
         chk({16'h0, vset_o}, 32'h30);
      end
      wr(`REG_VSET_ACT, 32'h55);
      rd(`REG_VSET_PEND, 32'h55);
      wr(`REG_TRK_PCT_I, 32'hC9);
      #1 chk({31'h0, err_o}, 32'h1);
      wr(`REG_TRK_PCT_I, 32'h5A);
      wr(`REG_TRIG_CTRL, 32'h10);
      rd(`REG_VSET_ACT, 32'h0);
      rd(`REG_VSET_PEND, 32'h0);
      rd(`REG_TRK_PCT_I, 32'h0);
      $display("trigger tests done");
      wr(`REG_CH_SEL, 32'h0);
      wr(`REG_CH_V, 32'hA);
      wr(`REG_CH_SEL, 32'h1);
      wr(`REG_CH_V, 32'h5);
      wr(`REG_TRK_CTRL, 32'h0001_0301);
      wr(`REG_VSET_ACT, 32'h1);
      #1 chk({31'h0, err_o}, 32'h1);
      wr(`REG_TRK_ABS_V, 32'hFFFF);
      tk(1);
      chk(ch_vset_o[31:0], 32'h0004_0009);
      wr(`REG_TRK_CTRL, 32'h0001_0303);
      wr(`REG_TRK_PCT_V, 32'h3C);
      tk(1);
      chk(ch_vset_o[31:0], 32'h0003_0006);
      rd(`REG_BASE_V, 32'h5);
      wr(`REG_TRK_CMD, 32'h1);
      wr(`REG_TRK_PCT_V, 32'h32);
      tk(1);
      chk(ch_vset_o[31:0], 32'h0001_0003);
      wr(`REG_TRK_CTRL, 32'h0002_0301);
      wr(`REG_TRK_ABS_V, 32'h7);
      tk(1);
      chk(ch_vset_o[47:16], 32'h0007_0001);
      $display("tracking tests done");
      wr(`REG_QUES_PTR, 32'h1);
      cv_req <= 4'h2;
      ov_req <= 4'h1;
      tk(3);
      rd(`REG_QINST_COND, 32'h0012_0001);
      rd(`REG_QUES_COND, 32'h1);
      rd(`REG_OPER_COND, 32'h100);
      rd(`REG_QUES_EVT, 32'h1);
      rd(`REG_QUES_EVT, 32'h0);
      wr(`REG_ESE, 32'h80);
      rd(`REG_ESE, 32'h80);
      rd(`REG_ERR_CNT, 32'h2);
      $display("status tests done");
      summarize();
   end
endmodule // psu_ctrl_tb
